// ### hw/mib_counter_pkg.sv
// Constants shared by the statistics counter indirect read block
package mib_counter_pkg;
  localparam logic [7:0] REG_INDIRECT_ACCESS_CONTROL = 8'h79;
  localparam logic [7:0] REG_INDIRECT_ADDRESS_LOW = 8'h7a;
  localparam logic [7:0] REG_INDIRECT_DATA_BYTE3 = 8'h80;
  localparam logic [7:0] REG_INDIRECT_DATA_BYTE2 = 8'h81;
  localparam logic [7:0] REG_INDIRECT_DATA_BYTE1 = 8'h82;
  localparam logic [7:0] REG_INDIRECT_DATA_BYTE0 = 8'h83;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Control byte upper bits that select a statistics read
  localparam logic [6:0] CONTROL_SELECT_COUNTERS = 7'h0e;
  localparam int CONTROL_ADDR8_BIT = 0;
  localparam int PORT_COUNT = 3;
  localparam int PORT_ENTRIES = 32;
  localparam logic [7:0] PORT1_BASE = 8'h00;
  localparam logic [7:0] PORT2_BASE = 8'h20;
  localparam logic [7:0] PORT3_BASE = 8'h40;
  localparam logic [8:0] DROP_BASE = 9'h100;
  localparam int DROP_COUNT = 6;
  localparam int PORT_COUNTER_WIDTH = 30;
  localparam int DROP_COUNTER_WIDTH = 16;
  localparam int FLAG_OVERFLOW_BIT = 31;
  localparam int FLAG_VALID_BIT = 30;
endpackage

// ### hw/stat_counter_cell.sv
// One per-port statistics counter with overflow and clear on read
`timescale 1ns/1ps
module stat_counter_cell
  import mib_counter_pkg::*;
#(
  parameter int WIDTH = PORT_COUNTER_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic event_i,
  input wire logic read_clear_i,
  output logic [WIDTH-1:0] count_o,
  output logic overflow_o
);
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] count_q;
  logic overflow_d;
  logic overflow_q;

  always_comb begin
    count_d = count_q;
    overflow_d = overflow_q;
    if (read_clear_i) begin
      // An event in the reading cycle is kept, not lost
      count_d = {{(WIDTH-1){1'b0}}, event_i};
      overflow_d = 1'b0;
    end else if (event_i) begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      if (&count_q) begin
        overflow_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      count_q <= '0;
      overflow_q <= 1'b0;
    end else begin
      count_q <= count_d;
      overflow_q <= overflow_d;
    end
  end

  assign count_o = count_q;
  assign overflow_o = overflow_q;
endmodule

// ### hw/mib_counter_indirect_read.sv
// Indirect read path for the switch statistics counters
`timescale 1ns/1ps
module mib_counter_indirect_read
  import mib_counter_pkg::*;
#(
  parameter int PORTS = PORT_COUNT,
  parameter int ENTRIES = PORT_ENTRIES,
  parameter int DROPS = DROP_COUNT
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [PORTS*ENTRIES-1:0] port_event_i,
  input wire logic [DROPS-1:0] drop_event_i
);
  ////////////////////////////////////////////////////////////////////////
  // Register state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LOAD = 2'b10
  } read_state_t;

  read_state_t state_d;
  read_state_t state_q;
  logic [7:0] control_d;
  logic [7:0] control_q;
  logic [7:0] address_d;
  logic [7:0] address_q;
  logic [31:0] data_d;
  logic [31:0] data_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_d;
  logic rvalid_q;

  logic [PORTS*ENTRIES-1:0] port_clear;
  logic [PORTS*ENTRIES*PORT_COUNTER_WIDTH-1:0] port_count;
  logic [PORTS*ENTRIES-1:0] port_overflow;
  logic [DROP_COUNTER_WIDTH-1:0] drop_count_d [DROPS];
  logic [DROP_COUNTER_WIDTH-1:0] drop_count_q [DROPS];

  logic [8:0] indirect_addr;
  logic start_read;

  // Strobe aimed at one register address
  function automatic logic reg_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && addr == target;
  endfunction

  function automatic logic is_port_entry(input logic [8:0] addr);
    return addr < 9'(PORTS * ENTRIES);
  endfunction

  function automatic logic is_drop_entry(input logic [8:0] addr);
    return addr >= DROP_BASE && addr < DROP_BASE + 9'(DROPS);
  endfunction

  assign indirect_addr = {control_q[CONTROL_ADDR8_BIT], address_q};
  // Any low address byte triggers; the stored control byte gates it
  assign start_read = reg_hit(reg_wr_i, reg_addr_i, REG_INDIRECT_ADDRESS_LOW)
    && control_q[7:1] == CONTROL_SELECT_COUNTERS;

  ////////////////////////////////////////////////////////////////////////
  // Per-port counters
  for (genvar i = 0; i < PORTS * ENTRIES; i++) begin : g_port
    // Clear pulse coincides with the snapshot into the data bytes
    assign port_clear[i] = state_q == ST_LOAD
      && is_port_entry(indirect_addr)
      && indirect_addr == 9'(i);
    stat_counter_cell #(
      .WIDTH(PORT_COUNTER_WIDTH)
    ) u_cell (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .event_i(port_event_i[i]),
      .read_clear_i(port_clear[i]),
      .count_o(port_count[i*PORT_COUNTER_WIDTH +: PORT_COUNTER_WIDTH]),
      .overflow_o(port_overflow[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Drop counters, wrapping silently and never cleared by a read
  always_comb begin
    for (int j = 0; j < DROPS; j++) begin
      drop_count_d[j] = drop_count_q[j] + 16'(drop_event_i[j]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    for (int j = 0; j < DROPS; j++) begin
      if (sys_rst_i) begin
        drop_count_q[j] <= '0;
      end else begin
        drop_count_q[j] <= drop_count_d[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and low address registers
  always_comb begin
    control_d = control_q;
    address_d = address_q;
    // Writes to the data bytes fall through: they are read-only
    if (reg_hit(reg_wr_i, reg_addr_i, REG_INDIRECT_ACCESS_CONTROL)) begin
      control_d = reg_wdata_i;
    end
    if (reg_hit(reg_wr_i, reg_addr_i, REG_INDIRECT_ADDRESS_LOW)) begin
      address_d = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      control_q <= CONTROL_RESET;
      address_q <= ADDRESS_RESET;
    end else begin
      control_q <= control_d;
      address_q <= address_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read sequencing and data snapshot
  always_comb begin
    int k;
    k = 0;
    state_d = state_q;
    data_d = data_q;
    case (state_q)
      ST_IDLE: begin
        if (start_read) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Address register has settled one cycle after the trigger
        state_d = ST_IDLE;
        // A trigger during the load restarts it with the new address
        if (start_read) begin
          state_d = ST_LOAD;
        end
        if (is_port_entry(indirect_addr)) begin
          k = int'(indirect_addr);
          data_d[FLAG_OVERFLOW_BIT] = port_overflow[k];
          data_d[FLAG_VALID_BIT] = 1'b1;
          data_d[PORT_COUNTER_WIDTH-1:0] =
            port_count[k*PORT_COUNTER_WIDTH +: PORT_COUNTER_WIDTH];
        end else if (is_drop_entry(indirect_addr)) begin
          k = int'(indirect_addr - DROP_BASE);
          data_d = {16'h0000, drop_count_q[k]};
        end else begin
          data_d = {4{DATA_RESET}};
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      data_q <= {4{DATA_RESET}};
    end else begin
      state_q <= state_d;
      data_q <= data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  always_comb begin
    rvalid_d = reg_rd_i;
    case (reg_addr_i)
      REG_INDIRECT_ACCESS_CONTROL: rdata_d = control_q;
      REG_INDIRECT_ADDRESS_LOW: rdata_d = address_q;
      REG_INDIRECT_DATA_BYTE3: rdata_d = data_q[31:24];
      REG_INDIRECT_DATA_BYTE2: rdata_d = data_q[23:16];
      REG_INDIRECT_DATA_BYTE1: rdata_d = data_q[15:8];
      REG_INDIRECT_DATA_BYTE0: rdata_d = data_q[7:0];
      default: rdata_d = DATA_RESET;
    endcase
    // Idle cycles return zero so a stale byte never looks fresh
    if (!reg_rd_i) begin
      rdata_d = DATA_RESET;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_q <= DATA_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
endmodule

// ### verification/mib_counter_monitor.sv
// Assertion checker for the counter indirect read block
`timescale 1ns/1ps
module mib_counter_monitor
  import mib_counter_pkg::*;
#(
  parameter int PORTS = PORT_COUNT,
  parameter int ENTRIES = PORT_ENTRIES,
  parameter int DROPS = DROP_COUNT
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [PORTS*ENTRIES-1:0] port_event_i,
  input wire logic [DROPS-1:0] drop_event_i
);
  logic [7:0] ctl_q;
  logic [7:0] adr_q;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctl_q <= CONTROL_RESET;
      adr_q <= ADDRESS_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h79) ctl_q <= reg_wdata_i;
      if (reg_addr_i == 8'h7a) adr_q <= reg_wdata_i;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence wr_at(logic [7:0] a, logic [7:0] d);
    reg_wr_i && reg_addr_i == a && reg_wdata_i == d;
  endsequence
  sequence rd_at(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  quiet_bus_a: assert property (!reg_rd_i |=> !reg_rvalid_o &&
    reg_rdata_o == 8'h00) else $error("stray read data");
  ctl_readback_a: assert property (rd_at(8'h79) |=>
    reg_rdata_o == ctl_q) else $error("control readback");
  adr_readback_a: assert property (rd_at(8'h7a) |=>
    reg_rdata_o == adr_q) else $error("address readback");
  valid_flag_a: assert property (wr_at(8'h79, 8'h1c) ##2
    wr_at(8'h7a, 8'h0e) ##2 rd_at(8'h80) |=> reg_rdata_o[7:6] == 2'b01)
    else $error("flags wrong");
  drop_flags_a: assert property (wr_at(8'h79, 8'h1d) ##2
    wr_at(8'h7a, 8'h00) ##2 rd_at(8'h80) |=> reg_rdata_o == 8'h00)
    else $error("drop flags set");
  drop_high_a: assert property (wr_at(8'h79, 8'h1d) ##2
    wr_at(8'h7a, 8'h00) ##4 rd_at(8'h81) |=> reg_rdata_o == 8'h00)
    else $error("drop high byte");
  unmapped_zero_a: assert property (reg_rd_i && !(reg_addr_i inside
    {8'h79, 8'h7a, [8'h80:8'h83]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
endmodule
bind mib_counter_indirect_read mib_counter_monitor #(.PORTS(PORTS),
  .ENTRIES(ENTRIES), .DROPS(DROPS)) mon (.clk_sys_i, .sys_rst_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o, .port_event_i, .drop_event_i);

// ### verification/mgmt_host_model.sv
// Host model driving the management register port
`timescale 1ns/1ps
module mgmt_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = '0;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
    @(posedge clk_sys_i);
    {wr_o, wdata_o} <= {1'b0, ~d};
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    {rd_o, addr_o} <= {1'b1, a};
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_i;
  endtask
  // Select first, then the address write starts the fetch
  task automatic trig(input logic [7:0] c, input logic [7:0] a);
    put(8'h79, c);
    put(8'h7a, a);
  endtask
endmodule

// ### verification/mib_counter_indirect_read_tb.sv
// Testbench for the statistics counter indirect read block
`timescale 1ns/1ps
module mib_counter_indirect_read_tb;
  import mib_counter_pkg::*;
  typedef struct {logic [7:0] adr; int n; logic [31:0] exp;} row_t;
  row_t rows [4] = '{'{8'h0e, 3, 32'h40000003}, '{8'h0e, 0, 32'h40000000},
    '{8'h0e, 300, 32'h4000012c}, '{8'h2e, 5, 32'h40000005}};
  logic clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [95:0] port_event_i;
  logic [5:0] drop_event_i;
  int num_errors = 0;
  int checks_done = 0;
  mib_counter_indirect_read dut (.clk_sys_i, .sys_rst_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .port_event_i, .drop_event_i);
  mgmt_host_model host (.clk_sys_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input logic [101:0] m, input int n);
    repeat (n) @(posedge clk_sys_i) {drop_event_i, port_event_i} <= m;
    @(posedge clk_sys_i) {drop_event_i, port_event_i} <= '0;
  endtask
  task automatic read4(input logic [31:0] exp);
    for (int i = 0; i < 4; i++) begin
      host.get(8'h80 + 8'(i), d);
      check(d, exp[31-8*i -: 8]);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial begin
    sys_rst_i = 1'b1;
    {drop_event_i, port_event_i} = '0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    host.get(8'h79, d);
    check(d, CONTROL_RESET);
    host.get(8'h83, d);
    check(d, DATA_RESET);
    $display("reset test done");
    // Second row reads the same counter untouched, so it must be zero
    foreach (rows[i]) begin
      pulse(102'(1) << rows[i].adr, rows[i].n);
      host.trig(8'h1c, rows[i].adr);
      read4(rows[i].exp);
      $display("row %0d done", i);
    end
    pulse(102'(1) << 96, 7);
    repeat (2) begin
      host.trig(8'h1d, 8'h00);
      read4(32'h00000007);
    end
    $display("drop test done");
    host.put(8'h83, 8'h55);
    host.get(8'h83, d);
    check(d, 8'h07);
    host.get(8'h7b, d);
    check(d, 8'h00);
    host.get(8'h79, d);
    check(d, 8'h1d);
    $display("map test done");
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    host.get(8'h79, d);
    check(d, CONTROL_RESET);
    host.trig(8'h1d, 8'h00);
    read4(32'h00000000);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule
